// [hdl/aip_pkg.sv]
// constants, register layout and carrier types of the record input path control
package aip_pkg;
  // control port shape
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [6:0] PM1_ADDR = 7'h02;
  localparam logic [6:0] INCTL_ADDR = 7'h27;
  localparam logic [6:0] LGAIN_ADDR = 7'h28;
  localparam logic [6:0] RGAIN_ADDR = 7'h29;
  // power management one fields
  localparam int PM1_RAMP_BIT = 13;
  localparam int PM1_LAMP_BIT = 12;
  localparam int PM1_RADC_BIT = 11;
  localparam int PM1_LADC_BIT = 10;
  localparam int PM1_DMIC_BIT = 7;
  localparam int PM1_MICB_BIT = 4;
  // input control fields
  localparam int INC_SECOND_AUXILIARY_PIN_BIT = 8;
  localparam int INC_FIRST_AUXILIARY_PIN_BIT = 7;
  localparam int INC_MICLVL_BIT = 6;
  localparam int INC_RINV_BIT = 5;
  localparam int INC_LINV_BIT = 4;
  localparam int INC_RSEL_MSB = 3;
  localparam int INC_RSEL_LSB = 2;
  localparam int INC_LSEL_MSB = 1;
  localparam int INC_LSEL_LSB = 0;
  // gain register fields
  localparam int GAIN_VU_BIT = 8;
  localparam int GAIN_ZC_BIT = 7;
  localparam int GAIN_MUTE_BIT = 6;
  localparam int GAIN_CODE_MSB = 5;
  localparam int GAIN_CODE_LSB = 0;
  // values after reset
  localparam logic [1:0] SEL_RST = 2'h1;
  localparam logic INV_RST = 1'b1;
  localparam logic MUTE_RST = 1'b1;
  localparam logic [5:0] GAIN_CODE_RST = 6'h10;
  // channel indices
  localparam int CH_LEFT = 0;
  localparam int CH_RIGHT = 1;
  // zero-cross timeout, least time so rounded up
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEOUT_NS = 100000;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TO_CNT_W = 12;
  localparam logic [11:0] TIMEOUT_LAST = 12'(TIMEOUT_CYCLES - 1);
  // mic link: link clock cycles per mic clock phase and tap points
  localparam logic [2:0] DMIC_HALF = 3'h4;
  localparam logic [2:0] DMIC_TAP_LEFT = 3'h4;
  localparam logic [2:0] DMIC_TAP_RIGHT = 3'h0;

  typedef struct packed {
    logic rightAmpEnable;
    logic leftAmpEnable;
    logic rightConverterEnable;
    logic leftConverterEnable;
    logic digitalMicMode;
    logic micBiasEnable;
  } aip_pm1_type;

  typedef struct packed {
    logic secondAuxiliaryAudioCfg;
    logic firstAuxiliaryAudioCfg;
    logic micBiasLevel;
    logic rightInvSelect;
    logic leftInvSelect;
    logic [1:0] rightNoninvSelect;
    logic [1:0] leftNoninvSelect;
  } aip_inctl_type;

  typedef struct packed {
    logic zeroCrossGate;
    logic ampMute;
    logic [5:0] gainCode;
  } aip_gain_type;

  typedef struct packed {
    logic ampMute;
    logic [5:0] gainCode;
  } aip_amp_type;

  typedef struct packed {
    logic leftBit;
    logic rightBit;
  } aip_dmic_type;
endpackage

// [hdl/aip_gain_chan.sv]
// one channel of double-buffered gain with zero-cross gating and timeout
`timescale 1ns/1ps
module aip_gain_chan (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // pending value and apply request
  input wire logic [5:0] pendingCode,
  input wire logic applyReq,
  // zero-cross control
  input wire logic zcEnable,
  input wire logic zcPulse,
  input wire logic timeoutEnable,
  // applied gain
  output logic [5:0] activeCode,
  output logic waiting
);
  logic [5:0] active_r, active_nxt; // gain in force
  logic [5:0] staged_r, staged_nxt; // value caught at the strobe
  logic wait_r, wait_nxt; // deferred change outstanding
  logic [11:0] toCnt_r, toCnt_nxt; // timeout count

  // next state of the apply logic
  always_comb begin
    active_nxt = active_r;
    staged_nxt = staged_r;
    wait_nxt = wait_r;
    toCnt_nxt = '0;
    if (applyReq) begin
      staged_nxt = pendingCode;
      // [RULE10] immediate or deferred
      if (!zcEnable) begin
        active_nxt = pendingCode;
        wait_nxt = 1'b0;
      end else begin
        wait_nxt = 1'b1;
      end
    end else if (wait_r) begin
      // gate dropped while waiting: no reason to hold the change
      if (zcPulse || !zcEnable) begin
        active_nxt = staged_r;
        wait_nxt = 1'b0;
      // [RULE11] timeout fallback
      end else if (timeoutEnable) begin
        if (toCnt_r == aip_pkg::TIMEOUT_LAST) begin
          active_nxt = staged_r;
          wait_nxt = 1'b0;
        end else begin
          toCnt_nxt = toCnt_r + 12'h001;
        end
      end else begin
        // timeout clock stopped: count freezes, crossing still applies
        toCnt_nxt = toCnt_r;
      end
    end
  end

  // registers of the apply logic
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_r <= aip_pkg::GAIN_CODE_RST;
      staged_r <= aip_pkg::GAIN_CODE_RST;
      wait_r <= 1'b0;
      toCnt_r <= 12'h000;
    end else begin
      active_r <= active_nxt;
      staged_r <= staged_nxt;
      wait_r <= wait_nxt;
      toCnt_r <= toCnt_nxt;
    end
  end

  assign activeCode = active_r;
  assign waiting = wait_r;

  zcDefer_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE10]
    applyReq && zcEnable |=> $stable(active_r) && wait_r)
    else $error("gain changed without zero crossing");
  timeoutApply_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE11]
    wait_r && !applyReq && zcEnable && timeoutEnable && toCnt_r == aip_pkg::TIMEOUT_LAST
    |=> active_r == $past(staged_r) && !wait_r)
    else $error("timeout did not apply gain");
  zcTimeout_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    wait_r && !applyReq && toCnt_r == aip_pkg::TIMEOUT_LAST && timeoutEnable);
endmodule

// [hdl/aip_dmic_rx.sv]
// digital microphone clock generation and interleaved data capture on the link clock
`timescale 1ns/1ps
module aip_dmic_rx (
  // link clock and reset
  input wire logic micRefClk,
  input wire logic nrst,
  // mode level from the system domain
  input wire logic modeEnable,
  // microphone pins
  input wire logic digitalMicData,
  output logic digitalMicClock,
  // captured pair towards the system domain
  output logic pairToggle,
  output aip_pkg::aip_dmic_type pairData
);
  logic enS1_r, enS2_r; // mode synchroniser
  logic datS1_r, datS2_r; // data pin synchroniser
  logic [2:0] cnt_r, cnt_nxt; // phase counter, high then low half
  logic clk_r, clk_nxt; // mic clock out
  logic left_r, left_nxt; // left bit waiting for its right partner
  aip_pkg::aip_dmic_type pair_r, pair_nxt; // published pair
  logic tog_r, tog_nxt; // event toggle

  // synchronisers, first stages read only by second stages
  always_ff @(posedge micRefClk or negedge nrst) begin
    if (!nrst) begin
      enS1_r <= 1'b0;
      enS2_r <= 1'b0;
      datS1_r <= 1'b0;
      datS2_r <= 1'b0;
    end else begin
      enS1_r <= modeEnable;
      enS2_r <= enS1_r;
      datS1_r <= digitalMicData;
      datS2_r <= datS1_r;
    end
  end

  // next state of clock divider and capture
  always_comb begin
    cnt_nxt = '0;
    clk_nxt = 1'b0;
    left_nxt = left_r;
    pair_nxt = pair_r;
    tog_nxt = tog_r;
    if (enS2_r) begin
      cnt_nxt = cnt_r + 3'h1;
      // [RULE17] clock from link rate
      clk_nxt = (cnt_nxt < aip_pkg::DMIC_HALF);
      // [RULE18] mid high phase, left
      if (cnt_r == aip_pkg::DMIC_TAP_LEFT) begin
        left_nxt = datS2_r;
      end
      // [RULE18] mid low phase, right
      if (cnt_r == aip_pkg::DMIC_TAP_RIGHT) begin
        pair_nxt.leftBit = left_r;
        pair_nxt.rightBit = datS2_r;
        tog_nxt = ~tog_r;
      end
    end
    // [RULE15] clock low when disabled (clk_nxt default above)
  end

  // registers of the link logic
  always_ff @(posedge micRefClk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 3'h0;
      clk_r <= 1'b0;
      left_r <= 1'b0;
      pair_r <= '0;
      tog_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      left_r <= left_nxt;
      pair_r <= pair_nxt;
      tog_r <= tog_nxt;
    end
  end

  assign digitalMicClock = clk_r;
  assign pairToggle = tog_r;
  assign pairData = pair_r;

  clkHeldLow_a: assert property (@(posedge micRefClk) disable iff (!nrst) // [RULE15]
    !enS2_r |=> !clk_r)
    else $error("mic clock not low while disabled");
  leftTap_a: assert property (@(posedge micRefClk) disable iff (!nrst) // [RULE18]
    enS2_r && cnt_r == aip_pkg::DMIC_TAP_LEFT |=> left_r == $past(datS2_r))
    else $error("left bit not taken at its tap");
  micClock_c: cover property (@(posedge micRefClk) disable iff (!nrst)
    enS2_r && !clk_r ##1 clk_r);
endmodule

// [hdl/aip_input_path.sv]
// register bank and control of the record input path with mic link receiver
// Functional notes
// [RULE1] left amp enabled while its bit set
// [RULE2] right amp enabled while its bit set
// [RULE3] two-bit noninverting selectors, reset to first pin
// [RULE4] inverting selects midrail or second pin
// [RULE5] auxiliary pins audio config bits, reset zero
// [RULE6] mic bias enable and level bits
// [RULE7] six-bit gain code, reset zero dB
// [RULE8] per-channel mute bit, reset muted
// [RULE9] gain held pending until update strobe
// [RULE10] zero-cross gate defers gain change
// [RULE11] timeout applies deferred change without crossing
// [RULE12] software keeps system clock running on strobe
// [RULE13] software enables midrail and bias first
// [RULE14] mic mode feeds processing from mic link
// [RULE15] mic clock low while mode disabled
// [RULE16] software disables left amp in mic mode
// [RULE17] mic clock driven at converter rate
// [RULE18] sample each phase mid, high left
// [RULE19] left mic drives high, right low
// [RULE20] each mic releases pin for other
// [RULE21] right converter enable gates right data
// [RULE22] left converter enable gates left data
// [RULE23] software sets filters, rate and volume
// [RULE24] gain read returns latest pending code
`timescale 1ns/1ps
module aip_input_path (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic micRefClk,
  // control port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [6:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // timeout clock and zero-cross detectors
  input wire logic timeoutClockEnable,
  input wire logic [1:0] zeroCross,
  // converter samples
  input wire aip_pkg::aip_dmic_type adcSample,
  input wire logic adcValid,
  // analogue path controls
  output aip_pkg::aip_pm1_type pmCtl,
  output aip_pkg::aip_inctl_type inCtl,
  output aip_pkg::aip_amp_type leftAmp,
  output aip_pkg::aip_amp_type rightAmp,
  // microphone pins
  input wire logic digitalMicData,
  output logic digitalMicClock,
  // processing input
  output aip_pkg::aip_dmic_type dspSample,
  output logic dspLeftValid,
  output logic dspRightValid
);
  aip_pkg::aip_pm1_type pm_r, pm_nxt; // power management one
  aip_pkg::aip_inctl_type inCtl_r, inCtl_nxt; // input control
  aip_pkg::aip_gain_type gain_r [2]; // gain regs, indexed by channel
  aip_pkg::aip_gain_type gain_nxt [2];
  logic vu_r, vu_nxt; // update strobe, one cycle after the write
  logic [15:0] rdData_r, rdData_nxt; // read answer
  logic rdValid_r, rdValid_nxt; // read answer marker
  logic [5:0] chanActive [2]; // gain in force per channel
  logic [1:0] chanWait; // deferred change per channel
  logic [1:0] zcS1_r, zcS2_r, zcS3_r; // zero-cross synchronisers
  logic [1:0] zcPulse; // crossing seen
  logic pairToggle; // link event toggle
  aip_pkg::aip_dmic_type pairData; // link pair, stable a whole mic period
  logic pairS1_r, pairS2_r, pairS3_r; // toggle synchroniser
  logic pairEdge; // a new pair is ready
  aip_pkg::aip_dmic_type dsp_r, dsp_nxt; // processing sample
  logic dspL_r, dspL_nxt; // left sample marker
  logic dspR_r, dspR_nxt; // right sample marker

  // next state of the register bank
  always_comb begin
    logic [15:0] rdWord;
    rdWord = '0;
    pm_nxt = pm_r;
    inCtl_nxt = inCtl_r;
    gain_nxt = gain_r;
    vu_nxt = 1'b0;
    rdData_nxt = rdData_r;
    rdValid_nxt = 1'b0;
    if (regWrEn) begin
      case (regAddr)
        aip_pkg::PM1_ADDR: begin
          // [RULE1] left amp bit
          pm_nxt.leftAmpEnable = regWrData[aip_pkg::PM1_LAMP_BIT];
          // [RULE2] right amp bit
          pm_nxt.rightAmpEnable = regWrData[aip_pkg::PM1_RAMP_BIT];
          // [RULE21] right converter bit
          pm_nxt.rightConverterEnable = regWrData[aip_pkg::PM1_RADC_BIT];
          // [RULE22] left converter bit
          pm_nxt.leftConverterEnable = regWrData[aip_pkg::PM1_LADC_BIT];
          // [RULE14] mic mode bit
          pm_nxt.digitalMicMode = regWrData[aip_pkg::PM1_DMIC_BIT];
          // [RULE6] bias enable bit
          pm_nxt.micBiasEnable = regWrData[aip_pkg::PM1_MICB_BIT];
        end
        aip_pkg::INCTL_ADDR: begin
          // [RULE5] auxiliary audio config
          inCtl_nxt.secondAuxiliaryAudioCfg = regWrData[aip_pkg::INC_SECOND_AUXILIARY_PIN_BIT];
          inCtl_nxt.firstAuxiliaryAudioCfg = regWrData[aip_pkg::INC_FIRST_AUXILIARY_PIN_BIT];
          // [RULE6] bias level bit
          inCtl_nxt.micBiasLevel = regWrData[aip_pkg::INC_MICLVL_BIT];
          // [RULE4] inverting input selects
          inCtl_nxt.rightInvSelect = regWrData[aip_pkg::INC_RINV_BIT];
          inCtl_nxt.leftInvSelect = regWrData[aip_pkg::INC_LINV_BIT];
          // [RULE3] noninverting selectors, reserved code stored as written
          inCtl_nxt.rightNoninvSelect = regWrData[aip_pkg::INC_RSEL_MSB:aip_pkg::INC_RSEL_LSB];
          inCtl_nxt.leftNoninvSelect = regWrData[aip_pkg::INC_LSEL_MSB:aip_pkg::INC_LSEL_LSB];
        end
        aip_pkg::LGAIN_ADDR, aip_pkg::RGAIN_ADDR: begin
          // [RULE9] code goes to pending only
          gain_nxt[(regAddr == aip_pkg::LGAIN_ADDR) ? aip_pkg::CH_LEFT : aip_pkg::CH_RIGHT] = '{
            zeroCrossGate: regWrData[aip_pkg::GAIN_ZC_BIT],
            ampMute: regWrData[aip_pkg::GAIN_MUTE_BIT],
            gainCode: regWrData[aip_pkg::GAIN_CODE_MSB:aip_pkg::GAIN_CODE_LSB]};
          // [RULE9] strobe from either register
          vu_nxt = regWrData[aip_pkg::GAIN_VU_BIT];
        end
        default: begin
          // unmapped write is dropped
        end
      endcase
    end
    if (regRdEn) begin
      rdValid_nxt = 1'b1;
      case (regAddr)
        aip_pkg::PM1_ADDR: begin
          rdWord[aip_pkg::PM1_RAMP_BIT] = pm_r.rightAmpEnable;
          rdWord[aip_pkg::PM1_LAMP_BIT] = pm_r.leftAmpEnable;
          rdWord[aip_pkg::PM1_RADC_BIT] = pm_r.rightConverterEnable;
          rdWord[aip_pkg::PM1_LADC_BIT] = pm_r.leftConverterEnable;
          rdWord[aip_pkg::PM1_DMIC_BIT] = pm_r.digitalMicMode;
          rdWord[aip_pkg::PM1_MICB_BIT] = pm_r.micBiasEnable;
        end
        aip_pkg::INCTL_ADDR: begin
          rdWord[aip_pkg::INC_SECOND_AUXILIARY_PIN_BIT] = inCtl_r.secondAuxiliaryAudioCfg;
          rdWord[aip_pkg::INC_FIRST_AUXILIARY_PIN_BIT] = inCtl_r.firstAuxiliaryAudioCfg;
          rdWord[aip_pkg::INC_MICLVL_BIT] = inCtl_r.micBiasLevel;
          rdWord[aip_pkg::INC_RINV_BIT] = inCtl_r.rightInvSelect;
          rdWord[aip_pkg::INC_LINV_BIT] = inCtl_r.leftInvSelect;
          rdWord[aip_pkg::INC_RSEL_MSB:aip_pkg::INC_RSEL_LSB] = inCtl_r.rightNoninvSelect;
          rdWord[aip_pkg::INC_LSEL_MSB:aip_pkg::INC_LSEL_LSB] = inCtl_r.leftNoninvSelect;
        end
        aip_pkg::LGAIN_ADDR, aip_pkg::RGAIN_ADDR: begin
          // [RULE24] pending code read back; strobe bit reads zero
          rdWord[aip_pkg::GAIN_ZC_BIT:aip_pkg::GAIN_CODE_LSB] =
            gain_r[(regAddr == aip_pkg::LGAIN_ADDR) ? aip_pkg::CH_LEFT : aip_pkg::CH_RIGHT];
        end
        default: begin
          // unmapped read answers zero
          rdWord = '0;
        end
      endcase
      rdData_nxt = rdWord;
    end
  end

  // registers of the bank
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pm_r <= '0;
      inCtl_r <= '{secondAuxiliaryAudioCfg: 1'b0, firstAuxiliaryAudioCfg: 1'b0, micBiasLevel: 1'b0,
                   rightInvSelect: aip_pkg::INV_RST, leftInvSelect: aip_pkg::INV_RST,
                   rightNoninvSelect: aip_pkg::SEL_RST, leftNoninvSelect: aip_pkg::SEL_RST};
      // [RULE7] zero dB, [RULE8] muted
      gain_r[0] <= '{zeroCrossGate: 1'b0, ampMute: aip_pkg::MUTE_RST, gainCode: aip_pkg::GAIN_CODE_RST};
      gain_r[1] <= '{zeroCrossGate: 1'b0, ampMute: aip_pkg::MUTE_RST, gainCode: aip_pkg::GAIN_CODE_RST};
      vu_r <= 1'b0;
      rdData_r <= 16'h0000;
      rdValid_r <= 1'b0;
    end else begin
      pm_r <= pm_nxt;
      inCtl_r <= inCtl_nxt;
      gain_r <= gain_nxt;
      vu_r <= vu_nxt;
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // zero-cross syncs, edge taken from the second and third stages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      zcS1_r <= 2'h0;
      zcS2_r <= 2'h0;
      zcS3_r <= 2'h0;
    end else begin
      zcS1_r <= zeroCross;
      zcS2_r <= zcS1_r;
      zcS3_r <= zcS2_r;
    end
  end
  assign zcPulse = zcS2_r & ~zcS3_r;

  // one gain channel per side; strobe lands a cycle after the write so the new code is pending
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    aip_gain_chan u_chan (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pendingCode(gain_r[ch].gainCode),
      .applyReq(vu_r),
      .zcEnable(gain_r[ch].zeroCrossGate),
      .zcPulse(zcPulse[ch]),
      .timeoutEnable(timeoutClockEnable),
      .activeCode(chanActive[ch]),
      .waiting(chanWait[ch])
    );
  end

  // link logic on its own clock
  aip_dmic_rx u_dmic (
    .micRefClk(micRefClk),
    .nrst(nrst),
    .modeEnable(pm_r.digitalMicMode),
    .digitalMicData(digitalMicData),
    .digitalMicClock(digitalMicClock),
    .pairToggle(pairToggle),
    .pairData(pairData)
  );

  // toggle crossing; pair data is quiet long after the toggle moves
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pairS1_r <= 1'b0;
      pairS2_r <= 1'b0;
      pairS3_r <= 1'b0;
    end else begin
      pairS1_r <= pairToggle;
      pairS2_r <= pairS1_r;
      pairS3_r <= pairS2_r;
    end
  end
  assign pairEdge = pairS2_r ^ pairS3_r;

  // next state of the processing input
  always_comb begin
    dsp_nxt = dsp_r;
    dspL_nxt = 1'b0;
    dspR_nxt = 1'b0;
    // [RULE14] source select
    if (pm_r.digitalMicMode) begin
      if (pairEdge) begin
        dsp_nxt = pairData;
        // [RULE22] left gated
        dspL_nxt = pm_r.leftConverterEnable;
        // [RULE21] right gated
        dspR_nxt = pm_r.rightConverterEnable;
      end
    end else if (adcValid) begin
      // [RULE14] converter path while mic mode off
      dsp_nxt = adcSample;
      dspL_nxt = pm_r.leftConverterEnable;
      dspR_nxt = pm_r.rightConverterEnable;
    end
  end

  // registers of the processing input
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dsp_r <= '0;
      dspL_r <= 1'b0;
      dspR_r <= 1'b0;
    end else begin
      dsp_r <= dsp_nxt;
      dspL_r <= dspL_nxt;
      dspR_r <= dspR_nxt;
    end
  end

  // outputs, all from flops
  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign pmCtl = pm_r;
  assign inCtl = inCtl_r;
  // [RULE8] mute acts at once, only the code waits for the strobe
  assign leftAmp = '{ampMute: gain_r[aip_pkg::CH_LEFT].ampMute, gainCode: chanActive[aip_pkg::CH_LEFT]};
  assign rightAmp = '{ampMute: gain_r[aip_pkg::CH_RIGHT].ampMute, gainCode: chanActive[aip_pkg::CH_RIGHT]};
  assign dspSample = dsp_r;
  assign dspLeftValid = dspL_r;
  assign dspRightValid = dspR_r;

  leftAmpEn_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE1]
    regWrEn && regAddr == aip_pkg::PM1_ADDR |=> pmCtl.leftAmpEnable == $past(regWrData[12]))
    else $error("left amp enable not following write");
  rightAmpEn_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE2]
    regWrEn && regAddr == aip_pkg::PM1_ADDR |=> pmCtl.rightAmpEnable == $past(regWrData[13]))
    else $error("right amp enable not following write");
  micBias_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE6]
    regWrEn && regAddr == aip_pkg::INCTL_ADDR |=> inCtl.micBiasLevel == $past(regWrData[6]))
    else $error("bias level not following write");
  pendingHold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE9]
    regWrEn && regAddr == aip_pkg::LGAIN_ADDR && !regWrData[8] && !vu_r && !chanWait[0]
    |=> $stable(leftAmp.gainCode))
    else $error("gain changed without strobe");
  strobeApply_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE9]
    regWrEn && regAddr == aip_pkg::LGAIN_ADDR && regWrData[8] && !regWrData[7]
    |-> ##2 leftAmp.gainCode == $past(regWrData[5:0], 2))
    else $error("strobe did not apply left gain");
  pendingRead_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE24]
    regWrEn && regAddr == aip_pkg::RGAIN_ADDR ##1 regRdEn && !regWrEn && regAddr == aip_pkg::RGAIN_ADDR
    |=> regRdValid && regRdData[5:0] == $past(regWrData[5:0], 2))
    else $error("gain read not pending code");
  adcPath_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE14]
    !pm_r.digitalMicMode && adcValid |=> dspSample == $past(adcSample)
    && dspLeftValid == $past(pm_r.leftConverterEnable))
    else $error("converter sample not passed");
  // [RULE14] mic pairs refused off mode
  micRefused_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE14]
    !pm_r.digitalMicMode && !adcValid |=> !dspLeftValid && !dspRightValid)
    else $error("valid without a converter sample");
  // [RULE21] right valid gated
  rightGate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE21]
    pm_r.digitalMicMode && pairEdge |=> dspRightValid == $past(pm_r.rightConverterEnable))
    else $error("right valid not gated by its enable");
  // [RULE22] left valid gated
  leftGate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE22]
    pm_r.digitalMicMode && pairEdge |=> dspLeftValid == $past(pm_r.leftConverterEnable))
    else $error("left valid not gated by its enable");
  // [RULE8] mute follows write
  muteNow_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE8]
    regWrEn && regAddr == aip_pkg::RGAIN_ADDR |=> rightAmp.ampMute == $past(regWrData[6]))
    else $error("right mute not following write");
  // [RULE9] right applied by strobe
  strobeRight_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE9]
    regWrEn && regAddr == aip_pkg::RGAIN_ADDR && regWrData[8] && !regWrData[7]
    |-> ##2 rightAmp.gainCode == $past(regWrData[5:0], 2))
    else $error("strobe did not apply right gain");
  // [RULE3] selectors follow write
  selFollow_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE3]
    regWrEn && regAddr == aip_pkg::INCTL_ADDR |=> inCtl.rightNoninvSelect == $past(regWrData[3:2])
    && inCtl.leftNoninvSelect == $past(regWrData[1:0]))
    else $error("input selectors not following write");
  // main scenarios: a mic pair delivered, a strobe with nothing waiting
  micPath_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    pm_r.digitalMicMode && pairEdge ##1 dspLeftValid && dspRightValid);
  strobe_c: cover property (@(posedge ref_clk) disable iff (!nrst) vu_r && chanWait == 2'h0);
endmodule

// [sim/aip_mic_model.sv]
// behavioural pair of interleaved microphones sharing one data pin
`timescale 1ns/1ps
module aip_mic_model (
  // mic clock from the receiver
  input wire logic micClock,
  // bits each mic sends
  input wire logic leftBit,
  input wire logic rightBit,
  // shared data pin
  output logic micData
);
  initial micData = 1'b0;
  // left in high phase, right in low
  // turnaround shows junk first, so an edge-time sample is caught
  always @(micClock) begin
    micData = ~micData;
    #10 micData = micClock ? leftBit : rightBit;
  end
endmodule

// [sim/aip_input_path_tb_top.sv]
// register, gain update and mic link checks of the record input path
`timescale 1ns/1ps
module aip_input_path_tb_top;
  // stimulus and observed pins
  logic ref_clk = 1'b0, micRefClk = 1'b0, nrst = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, adcValid = 1'b0;
  logic timeoutClockEnable = 1'b0, lBit = 1'b1, rBit = 1'b0;
  logic digitalMicData, digitalMicClock, regRdValid, dspLeftValid, dspRightValid;
  logic [6:0] regAddr = 7'h00;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [1:0] zeroCross = 2'h0;
  aip_pkg::aip_dmic_type adcSample = 2'h0, dspSample;
  aip_pkg::aip_pm1_type pmCtl;
  aip_pkg::aip_inctl_type inCtl;
  aip_pkg::aip_amp_type leftAmp, rightAmp;
  int miscompares = 0, nCompared = 0;
  // clocks of unrelated rate
  always #12.5 ref_clk = ~ref_clk;
  always #16 micRefClk = ~micRefClk;
  aip_input_path DUT (.ref_clk, .nrst, .micRefClk, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid, .timeoutClockEnable, .zeroCross, .adcSample, .adcValid, .pmCtl, .inCtl, .leftAmp, .rightAmp,
    .digitalMicData, .digitalMicClock, .dspSample, .dspLeftValid, .dspRightValid);
  aip_mic_model MIC (.micClock(digitalMicClock), .leftBit(lBit), .rightBit(rBit), .micData(digitalMicData));
  task automatic wrap_up;
    if (miscompares == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // n cycles, landing just after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // idle cycle after each strobe so it is never re-raised in one step
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    int i;
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    for (i = 0; i < 3 && regRdValid !== 1'b1; i++) cyc(1);
    chk({15'h0, regRdValid}, 16'h0001);
    chk(regRdData, e);
    cyc(1);
  endtask
  // bounded wait for a left pulse, then valids and pair
  task automatic pair(input logic [1:0] ev, input logic [1:0] es);
    int i;
    for (i = 0; i < 200 && dspLeftValid !== 1'b1; i++) cyc(1);
    chk({14'h0, dspLeftValid, dspRightValid}, {14'h0, ev});
    chk({14'h0, dspSample}, {14'h0, es});
    cyc(1);
  endtask
  // hang guard, well beyond the longest timeout wait
  initial begin
    #(8000 * 25);
    miscompares++;
    wrap_up;
  end
  initial begin
    cyc(6);
    nrst = 1'b1;
    rd(aip_pkg::PM1_ADDR, 16'h0000);
    rd(aip_pkg::INCTL_ADDR, 16'h0035);
    rd(aip_pkg::RGAIN_ADDR, 16'h0050);
    chk({9'h0, leftAmp}, 16'h0050);
    chk({15'h0, digitalMicClock}, 16'h0000);
    wr(aip_pkg::PM1_ADDR, 16'h3c10); // midrail and bias taken as up
    chk({10'h0, pmCtl}, 16'h003d);
    wr(aip_pkg::INCTL_ADDR, 16'h01ff);
    chk({7'h0, inCtl}, 16'h01ff);
    wr(aip_pkg::INCTL_ADDR, 16'h0086);
    chk({7'h0, inCtl}, 16'h0086);
    rd(7'h30, 16'h0000);
    // pending code, mute at once
    wr(aip_pkg::LGAIN_ADDR, 16'h0003);
    cyc(3);
    chk({9'h0, leftAmp}, 16'h0010);
    rd(aip_pkg::LGAIN_ADDR, 16'h0003);
    wr(aip_pkg::RGAIN_ADDR, 16'h0105); // system clock always running
    cyc(3);
    chk({2'h0, leftAmp, rightAmp}, 16'h0185);
    rd(aip_pkg::RGAIN_ADDR, 16'h0005);
    // left waits for its crossing, right goes at once
    wr(aip_pkg::LGAIN_ADDR, 16'h0087);
    wr(aip_pkg::RGAIN_ADDR, 16'h0109);
    cyc(3);
    chk({2'h0, leftAmp, rightAmp}, 16'h0189);
    zeroCross = 2'h1;
    cyc(3);
    zeroCross = 2'h0;
    cyc(4);
    chk({9'h0, leftAmp}, 16'h0007);
    // no crossing: timeout after 4000 cycles
    timeoutClockEnable = 1'b1;
    wr(aip_pkg::LGAIN_ADDR, 16'h0188);
    cyc(3900);
    chk({9'h0, leftAmp}, 16'h0007);
    cyc(200);
    chk({9'h0, leftAmp}, 16'h0008);
    // mic link, both converters on; first pair after enable holds a stale left bit
    wr(aip_pkg::PM1_ADDR, 16'h2c90);
    chk({10'h0, pmCtl}, 16'h002f);
    cyc(12);
    pair(2'h3, 2'h2);
    lBit = 1'b0;
    rBit = 1'b1;
    cyc(25);
    pair(2'h3, 2'h1);
    wr(aip_pkg::PM1_ADDR, 16'h0490);
    cyc(25);
    pair(2'h2, 2'h1);
    wr(aip_pkg::PM1_ADDR, 16'h0c10);
    cyc(10);
    repeat (40) begin
      chk({14'h0, digitalMicClock, dspLeftValid}, 16'h0000);
      cyc(1);
    end
    // converter path carries the sample
    adcSample = 2'h2;
    adcValid = 1'b1;
    cyc(1);
    adcValid = 1'b0;
    chk({14'h0, dspLeftValid, dspRightValid}, 16'h0003);
    chk({14'h0, dspSample}, 16'h0002);
    wrap_up;
  end
endmodule
